//--- logic/seq_consts.svh
// constants for the touch scan power sequencer
// assumes a 50 MHz system clock and a slow free-running wake clock pin
`ifndef SEQ_CONSTS_SVH
`define SEQ_CONSTS_SVH

// counter width for periods and the idle limit, in wake clock ticks
`define SEQ_CNT_W 16
// wake clock rate; the default is a plain stand-in value
`define WAKE_CLK_HZ 1000
// refresh rates of the slow and the active scan states
`define SLOW_RATE_HZ 8
`define FAST_RATE_HZ 45
// default counts of wake ticks for both periods and the idle fallback
`define SLOW_PERIOD_DEF (`WAKE_CLK_HZ / `SLOW_RATE_HZ)
`define FAST_PERIOD_DEF (`WAKE_CLK_HZ / `FAST_RATE_HZ)
`define IDLE_LIMIT_DEF (`WAKE_CLK_HZ * 2)
// bit positions of the gpio edge select
`define EDGE_RISE_BIT 0
`define EDGE_FALL_BIT 1
// reset value of the pin synchroniser chain
`define SYNC_RST_VAL 3'h0

`endif

//--- logic/seq_pkg.sv
// types of the touch scan power sequencer
// assumes seq_consts.svh is on the include path
`default_nettype none
`include "seq_consts.svh"

package seq_pkg;

  typedef enum logic [1:0] {
    PM_ACTIVE = 2'b00,
    PM_SLEEP  = 2'b01,
    PM_DEEP   = 2'b10
  } power_mode_t;

  typedef enum logic [2:0] {
    ST_DEEP  = 3'b000,
    ST_START = 3'b001,
    ST_SCAN  = 3'b010,
    ST_EVAL  = 3'b011,
    ST_I2C   = 3'b100
  } seq_state_t;

  typedef enum logic [1:0] {
    KIND_INDIV = 2'b00,
    KIND_GANG  = 2'b01,
    KIND_PROX  = 2'b10
  } scan_kind_t;

  typedef struct packed {
    seq_state_t             state;
    scan_kind_t             kind;
    logic                   fast;
    logic [`SEQ_CNT_W-1:0]  period_cnt;
    logic [`SEQ_CNT_W-1:0]  idle_cnt;
    logic                   tmr_pend;
    logic                   gpio_pend;
    logic                   i2c_pend;
    logic                   scan_pend;
    logic                   scan_start;
    logic                   backlight;
  } seq_regs_t;

  typedef struct packed {
    logic [2:0] sh;
    logic       level;
    logic       rise;
    logic       fall;
  } sync_regs_t;

endpackage

`default_nettype wire

//--- logic/pin_sync3.sv
// three-stage synchroniser with edge pulses for one pin
// assumes the pin is asynchronous to sys_clk
`default_nettype none
`include "seq_consts.svh"

module pin_sync3 (
  input  wire logic sys_clk,
  input  wire logic sys_rst,
  input  wire logic pin,
  output logic      level,
  output logic      rise,
  output logic      fall
);

  seq_pkg::sync_regs_t sync_reg;
  seq_pkg::sync_regs_t sync_next;

  // a change counts only once stages two and three agree
  always_comb begin
    sync_next = sync_reg;
    sync_next.sh = {sync_reg.sh[1:0], pin};
    sync_next.rise = 1'b0;
    sync_next.fall = 1'b0;
    if (sync_reg.sh[1] == sync_reg.sh[2]) begin
      sync_next.level = sync_reg.sh[2];
      sync_next.rise = sync_reg.sh[2] & ~sync_reg.level;
      sync_next.fall = ~sync_reg.sh[2] & sync_reg.level;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      sync_reg <= '{sh: `SYNC_RST_VAL, level: 1'b0, rise: 1'b0,
                    fall: 1'b0};
    end else begin
      sync_reg <= sync_next;
    end
  end

  assign level = sync_reg.level;
  assign rise  = sync_reg.rise;
  assign fall  = sync_reg.fall;

endmodule // pin_sync3

`default_nettype wire

//--- logic/touch_scan_power_sequencer.sv
// power mode sequencer around capacitive touch scanning
// assumes scan hardware and serial block on sys_clk, wake clock on a pin
//
// Overview of operation
// - scan hardware is off in deep sleep; scans start only after waking.
// - periodic wake timer wakes from deep sleep and sets the scan rate.
// - gpio rising, falling or both edges wake the device, selectable.
// - own i2c slave address match wakes the device from deep sleep.
// - after address wake, stay active until results returned, then deep.
// - i2c traffic for other devices never wakes the device.
// - a started scan completes alone while the processor sleeps.
// - scan completion interrupt returns the device from sleep to active.
// - standby scans all wake sensors ganged as one sensor.
// - ganged touch leads to active mode and individual sensor scans.
// - no touch for the idle period returns to ganged standby scanning.
// - proximity mode scans only the proximity sensor on each wake.
// - proximity active keeps active and scans others; else deep sleep.
// - backlight off in standby, on when proximity detects a hand.
// - start in the slow state refreshing at 8 Hz.
// - a touch moves to active scanning at 45 Hz.
// - no touch for the idle period returns to 8 Hz.
// - in sleep the processor clock stops while peripherals keep running.
// - any pending timer, gpio or address wake in deep sleep returns to active.
`default_nettype none
`include "seq_consts.svh"

module touch_scan_power_sequencer #(
  parameter int CNT_W = `SEQ_CNT_W
) (
  input  wire logic             sys_clk,
  input  wire logic             sys_rst,
  input  wire logic             wake_clk_pin,
  input  wire logic             gpio_pin,
  input  wire logic [1:0]       gpio_edge_sel,
  input  wire logic             i2c_addr_match,
  input  wire logic             i2c_done,
  input  wire logic             scan_done,
  input  wire logic             touch_detected,
  input  wire logic             gang_mode,
  input  wire logic             prox_mode,
  input  wire logic [CNT_W-1:0] slow_period,
  input  wire logic [CNT_W-1:0] fast_period,
  input  wire logic [CNT_W-1:0] idle_limit,
  output seq_pkg::power_mode_t  power_mode,
  output logic                  processor_clk_en,
  output logic                  scan_hw_en,
  output logic                  scan_start,
  output logic                  gang_connect,
  output logic                  prox_only,
  output logic                  fast_rate,
  output logic                  backlight_on,
  output logic                  scan_irq_pending
);

  seq_pkg::seq_regs_t seq_reg;
  seq_pkg::seq_regs_t seq_next;

  logic             wake_tick;
  logic             gpio_rise;
  logic             gpio_fall;
  logic             gpio_ev;
  logic             tmr_ev;
  logic [CNT_W-1:0] cur_period;
  logic [CNT_W-1:0] cnt_inc;
  seq_pkg::scan_kind_t standby_kind;

  // wake clock is only sampled; its rising edge is a one-cycle tick
  pin_sync3 u_wake_sync (
    .sys_clk (sys_clk),
    .sys_rst (sys_rst),
    .pin     (wake_clk_pin),
    .level   (),
    .rise    (wake_tick),
    .fall    ()
  );

  // one chain gives both edges; two chains could disagree on the pin
  pin_sync3 u_gpio_sync (
    .sys_clk (sys_clk),
    .sys_rst (sys_rst),
    .pin     (gpio_pin),
    .level   (),
    .rise    (gpio_rise),
    .fall    (gpio_fall)
  );

  // edge selection for the gpio wake
  assign gpio_ev = (gpio_rise & gpio_edge_sel[`EDGE_RISE_BIT]) |
                   (gpio_fall & gpio_edge_sel[`EDGE_FALL_BIT]);

  // period follows the refresh state; zero is treated as one tick
  always_comb begin
    cur_period = seq_reg.fast ? fast_period : slow_period;
    if (cur_period == '0) begin
      cur_period = {{(CNT_W-1){1'b0}}, 1'b1};
    end
  end

  assign cnt_inc = seq_reg.period_cnt + {{(CNT_W-1){1'b0}}, 1'b1};
  assign tmr_ev  = wake_tick && (cnt_inc >= cur_period);

  // standby scan kind from the configured wake strategy
  always_comb begin
    if (prox_mode) begin
      standby_kind = seq_pkg::KIND_PROX;
    end else if (gang_mode) begin
      standby_kind = seq_pkg::KIND_GANG;
    end else begin
      standby_kind = seq_pkg::KIND_INDIV;
    end
  end

  // next state; clears first, event sets last so a set wins a clear
  always_comb begin
    seq_next = seq_reg;
    seq_next.scan_start = 1'b0;
    if (wake_tick) begin
      seq_next.period_cnt = tmr_ev ? '0 : cnt_inc;
      if (seq_reg.fast && seq_reg.idle_cnt != '1) begin
        seq_next.idle_cnt = seq_reg.idle_cnt +
                            {{(CNT_W-1){1'b0}}, 1'b1};
      end
    end
    unique case (seq_reg.state)
      seq_pkg::ST_DEEP: begin
        // address match served first, results go back before scanning
        if (seq_reg.i2c_pend) begin
          seq_next.i2c_pend = 1'b0;
          seq_next.state = seq_pkg::ST_I2C;
        end else if (seq_reg.tmr_pend || seq_reg.gpio_pend) begin
          seq_next.tmr_pend = 1'b0;
          seq_next.gpio_pend = 1'b0;
          if (!seq_reg.fast) begin
            seq_next.kind = standby_kind;
          end
          seq_next.state = seq_pkg::ST_START;
        end
      end
      seq_pkg::ST_START: begin
        seq_next.scan_start = 1'b1;
        seq_next.state = seq_pkg::ST_SCAN;
      end
      seq_pkg::ST_SCAN: begin
        // processor sleeps here until the completion is seen
        if (seq_reg.scan_pend) begin
          seq_next.scan_pend = 1'b0;
          seq_next.state = seq_pkg::ST_EVAL;
        end
      end
      seq_pkg::ST_EVAL: begin
        seq_next.state = seq_pkg::ST_DEEP;
        unique case (seq_reg.kind)
          seq_pkg::KIND_GANG: begin
            if (touch_detected) begin
              seq_next.kind = seq_pkg::KIND_INDIV;
              seq_next.fast = 1'b1;
              seq_next.idle_cnt = '0;
              seq_next.backlight = 1'b1;
              seq_next.state = seq_pkg::ST_START;
            end
          end
          seq_pkg::KIND_PROX: begin
            if (touch_detected) begin
              seq_next.kind = seq_pkg::KIND_INDIV;
              seq_next.fast = 1'b1;
              seq_next.idle_cnt = '0;
              seq_next.backlight = 1'b1;
              seq_next.state = seq_pkg::ST_START;
            end else begin
              seq_next.backlight = 1'b0;
            end
          end
          seq_pkg::KIND_INDIV: begin
            if (touch_detected) begin
              seq_next.fast = 1'b1;
              seq_next.idle_cnt = '0;
              seq_next.backlight = 1'b1;
            end else if (seq_reg.fast &&
                         seq_reg.idle_cnt >= idle_limit) begin
              seq_next.fast = 1'b0;
              seq_next.kind = standby_kind;
              seq_next.backlight = 1'b0;
            end
          end
          default: begin
            seq_next.kind = standby_kind;
          end
        endcase
        // host is served only when no new scan follows; else it waits
        // pending so that a follow-up scan cannot swallow the request
        if (seq_reg.i2c_pend && seq_next.state == seq_pkg::ST_DEEP) begin
          seq_next.i2c_pend = 1'b0;
          seq_next.state = seq_pkg::ST_I2C;
        end
      end
      seq_pkg::ST_I2C: begin
        // stay active until the serial block has returned the results
        if (i2c_done) begin
          seq_next.state = seq_pkg::ST_DEEP;
        end
      end
      default: begin
        seq_next.state = seq_pkg::ST_DEEP;
      end
    endcase
    // event sets win over the clears above
    if (tmr_ev) begin
      seq_next.tmr_pend = 1'b1;
    end
    if (gpio_ev) begin
      seq_next.gpio_pend = 1'b1;
    end
    if (i2c_addr_match) begin
      seq_next.i2c_pend = 1'b1;
    end
    if (scan_done) begin
      seq_next.scan_pend = 1'b1;
    end
  end

  // reset lands in deep sleep, slow state, individual scan, backlight off
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      seq_reg <= '{state: seq_pkg::ST_DEEP, kind: seq_pkg::KIND_INDIV,
                   fast: 1'b0, period_cnt: '0, idle_cnt: '0,
                   tmr_pend: 1'b0, gpio_pend: 1'b0, i2c_pend: 1'b0,
                   scan_pend: 1'b0, scan_start: 1'b0,
                   backlight: 1'b0};
    end else begin
      seq_reg <= seq_next;
    end
  end

  // power mode decoded from the sequencer state
  always_comb begin
    unique case (seq_reg.state)
      seq_pkg::ST_DEEP: power_mode = seq_pkg::PM_DEEP;
      seq_pkg::ST_SCAN: power_mode = seq_pkg::PM_SLEEP;
      default:          power_mode = seq_pkg::PM_ACTIVE;
    endcase
  end

  assign processor_clk_en = (power_mode == seq_pkg::PM_ACTIVE);
  assign scan_hw_en       = (power_mode != seq_pkg::PM_DEEP);
  assign scan_start       = seq_reg.scan_start;
  assign gang_connect     = (seq_reg.kind == seq_pkg::KIND_GANG);
  assign prox_only        = (seq_reg.kind == seq_pkg::KIND_PROX);
  assign fast_rate        = seq_reg.fast;
  assign backlight_on     = seq_reg.backlight;
  assign scan_irq_pending = seq_reg.scan_pend;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  a_deep_no_scan: assert property (
    seq_reg.state == seq_pkg::ST_DEEP |-> !scan_hw_en && !scan_start)
    else $error("scan active in deep sleep");

  a_timer_wakes: assert property (
    seq_reg.state == seq_pkg::ST_DEEP && seq_reg.tmr_pend &&
    !seq_reg.i2c_pend |=> seq_reg.state == seq_pkg::ST_START ##1 scan_start)
    else $error("timer wake did not start a scan");

  a_gpio_latched: assert property (
    gpio_ev |=> seq_reg.gpio_pend)
    else $error("gpio edge lost");

  a_i2c_wakes: assert property (
    seq_reg.state == seq_pkg::ST_DEEP && seq_reg.i2c_pend
    |=> seq_reg.state == seq_pkg::ST_I2C && processor_clk_en)
    else $error("address match did not wake");

  a_i2c_return: assert property (
    seq_reg.state == seq_pkg::ST_I2C && i2c_done
    |=> power_mode == seq_pkg::PM_DEEP)
    else $error("no return to deep sleep after results");

  a_i2c_own_only: assert property (
    $rose(seq_reg.i2c_pend) |-> $past(i2c_addr_match))
    else $error("wake without own address match");

  a_scan_sleeps: assert property (
    scan_start |-> power_mode == seq_pkg::PM_SLEEP && !processor_clk_en
    && scan_hw_en)
    else $error("processor not asleep during scan");

  a_done_wakes: assert property (
    seq_reg.state == seq_pkg::ST_SCAN && seq_reg.scan_pend
    |=> power_mode == seq_pkg::PM_ACTIVE)
    else $error("scan completion did not wake");

  a_gang_split: assert property (
    seq_reg.state == seq_pkg::ST_EVAL && gang_connect && touch_detected
    |=> !gang_connect && fast_rate ##1 scan_start)
    else $error("ganged touch not followed by split scan");

  a_prox_idle: assert property (
    seq_reg.state == seq_pkg::ST_EVAL && prox_only && !touch_detected
    && !seq_reg.i2c_pend |=> power_mode == seq_pkg::PM_DEEP
    && !backlight_on)
    else $error("inactive proximity did not return to deep sleep");

  a_idle_fallback: assert property (
    seq_reg.state == seq_pkg::ST_EVAL && fast_rate && !touch_detected
    && seq_reg.kind == seq_pkg::KIND_INDIV && seq_reg.idle_cnt >= idle_limit
    |=> !fast_rate)
    else $error("idle period did not drop to slow rate");

  a_done_kept: assert property (
    scan_done |=> scan_irq_pending)
    else $error("scan completion lost");

  a_eval_i2c_kept: assert property (
    seq_reg.state == seq_pkg::ST_EVAL && seq_reg.i2c_pend
    |=> seq_reg.i2c_pend || seq_reg.state == seq_pkg::ST_I2C)
    else $error("host request dropped after scan");

  a_dark_standby: assert property (
    !fast_rate |-> !backlight_on)
    else $error("backlight on in standby");

  a_prox_light: assert property (
    seq_reg.state == seq_pkg::ST_EVAL && prox_only && touch_detected
    |=> backlight_on && fast_rate && !prox_only)
    else $error("approach did not light the panel");

  a_gang_slow: assert property (
    gang_connect |-> !fast_rate)
    else $error("ganged sensor in active scanning");

  a_wake_active: assert property (
    seq_reg.state == seq_pkg::ST_DEEP
    && (seq_reg.tmr_pend || seq_reg.gpio_pend || seq_reg.i2c_pend)
    |=> power_mode == seq_pkg::PM_ACTIVE)
    else $error("pending wake left the device asleep");

  a_period_wrap: assert property (
    tmr_ev |=> seq_reg.period_cnt == '0 && seq_reg.tmr_pend)
    else $error("wake period did not restart");

  a_idle_counts: assert property (
    fast_rate && wake_tick && seq_reg.idle_cnt != '1
    && seq_reg.state != seq_pkg::ST_EVAL
    |=> seq_reg.idle_cnt == $past(seq_reg.idle_cnt) + 1'b1)
    else $error("idle count missed a wake tick");

endmodule // touch_scan_power_sequencer

`default_nettype wire

//--- dv/sensor_model.sv
// behavioural model of the scan hardware and the sensor field
// assumes scan_start pulses on sys_clk and touch_in is set by the bench
`default_nettype none
module sensor_model (
  input  wire logic       sys_clk,
  input  wire logic       sys_rst,
  input  wire logic       scan_hw_en,
  input  wire logic       scan_start,
  input  wire logic       touch_in,
  input  wire logic [7:0] delay,
  output logic            scan_done,
  output logic            touch_detected
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] cnt_reg;
  logic       busy_reg;
  logic       valid_reg;
  logic       touch_reg;

  // result holds only after completion; before it shows the opposite
  assign touch_detected = valid_reg ? touch_reg : ~touch_in;

  // one scan per start, finished unaided delay plus one cycles after the start
  always @(posedge sys_clk) begin
    scan_done <= 1'b0;
    if (sys_rst) begin
      busy_reg <= 1'b0;
      valid_reg <= 1'b0;
      touch_reg <= 1'b0;
      cnt_reg <= 8'h00;
    end else if (scan_start && scan_hw_en) begin
      busy_reg <= 1'b1;
      valid_reg <= 1'b0;
      cnt_reg <= delay;
    end else if (busy_reg && cnt_reg == 8'h00) begin
      busy_reg <= 1'b0;
      scan_done <= 1'b1;
      valid_reg <= 1'b1;
      touch_reg <= touch_in;
    end else if (busy_reg) begin
      cnt_reg <= cnt_reg - 8'h01;
    end
  end
endmodule // sensor_model
`default_nettype wire

//--- dv/tb_top.sv
// self-checking bench for the touch scan power sequencer
// assumes sensor_model stands in for the scan hardware
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic                 sys_clk;
  logic                 sys_rst;
  logic                 wake_clk_pin;
  logic                 gpio_pin;
  logic [1:0]           gpio_edge_sel;
  logic                 i2c_addr_match;
  logic                 i2c_done;
  logic                 scan_done;
  logic                 touch_detected;
  logic                 gang_mode;
  logic                 prox_mode;
  logic [15:0]          slow_period;
  logic [15:0]          fast_period;
  logic [15:0]          idle_limit;
  seq_pkg::power_mode_t power_mode;
  logic                 processor_clk_en;
  logic                 scan_hw_en;
  logic                 scan_start;
  logic                 gang_connect;
  logic                 prox_only;
  logic                 fast_rate;
  logic                 backlight_on;
  logic                 scan_irq_pending;
  logic                 touch_in;
  logic [7:0]           delay_cfg;
  int                   n_mismatch;
  int                   total_checks;

  touch_scan_power_sequencer uut (.sys_clk(sys_clk), .sys_rst(sys_rst),
    .wake_clk_pin(wake_clk_pin), .gpio_pin(gpio_pin),
    .gpio_edge_sel(gpio_edge_sel), .i2c_addr_match(i2c_addr_match),
    .i2c_done(i2c_done), .scan_done(scan_done),
    .touch_detected(touch_detected), .gang_mode(gang_mode),
    .prox_mode(prox_mode), .slow_period(slow_period),
    .fast_period(fast_period), .idle_limit(idle_limit),
    .power_mode(power_mode), .processor_clk_en(processor_clk_en),
    .scan_hw_en(scan_hw_en), .scan_start(scan_start),
    .gang_connect(gang_connect), .prox_only(prox_only),
    .fast_rate(fast_rate), .backlight_on(backlight_on),
    .scan_irq_pending(scan_irq_pending));

  sensor_model sensors (.sys_clk(sys_clk), .sys_rst(sys_rst),
    .scan_hw_en(scan_hw_en), .scan_start(scan_start),
    .touch_in(touch_in), .delay(delay_cfg), .scan_done(scan_done),
    .touch_detected(touch_detected));

  // 50 MHz system clock
  always #10 sys_clk = ~sys_clk;

  // slow wake clock, odd offset keeps it unrelated to sys_clk
  initial begin
    wake_clk_pin = 1'b0;
    #7;
    forever #400 wake_clk_pin = ~wake_clk_pin;
  end

  task automatic wrap_up();
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic chk_bit(input string what, input logic exp, input logic got);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s expected %b seen %b", what, exp, got);
    end
  endtask

  task automatic chk_mode(input string what, input seq_pkg::power_mode_t exp);
    total_checks++;
    if (power_mode !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", what, exp, power_mode);
    end
  endtask

  // condition selector for the bounded waits
  function automatic logic pick(input int w);
    case (w)
      0: pick = (scan_start === 1'b1);
      1: pick = (power_mode === seq_pkg::PM_ACTIVE);
      2: pick = (power_mode === seq_pkg::PM_DEEP);
      3: pick = (fast_rate === 1'b0);
      default: pick = (scan_irq_pending === 1'b1);
    endcase
  endfunction

  // a wait that runs out ends the run at once
  task automatic wait_for(input int w, input int bound);
    int i;
    i = 0;
    while (pick(w) !== 1'b1 && i < bound) begin
      @(negedge sys_clk);
      i++;
    end
    total_checks++;
    if (i >= bound) begin
      n_mismatch++;
      $display("MISMATCH wait %0d expected 1 seen 0", w);
      wrap_up();
    end
  endtask

  task automatic t_reset();
    chk_mode("reset mode", seq_pkg::PM_DEEP);
    chk_bit("reset scan_hw_en", 1'b0, scan_hw_en);
    chk_bit("reset fast_rate", 1'b0, fast_rate);
  endtask

  // timer wake, ganged standby, touch, then idle fallback
  task automatic t_gang();
    gang_mode = 1'b1;
    wait_for(0, 1000);
    chk_bit("gang_connect", 1'b1, gang_connect);
    chk_mode("sleep in scan", seq_pkg::PM_SLEEP);
    chk_bit("cpu clock", 1'b0, processor_clk_en);
    chk_bit("slow rate", 1'b0, fast_rate);
    wait_for(1, 40);
    wait_for(2, 10);
    chk_bit("hw off deep", 1'b0, scan_hw_en);
    touch_in = 1'b1;
    wait_for(0, 1000);
    wait_for(1, 40);
    wait_for(0, 10);
    chk_bit("fast rate", 1'b1, fast_rate);
    chk_bit("ungang", 1'b0, gang_connect);
    chk_bit("light on", 1'b1, backlight_on);
    touch_in = 1'b0;
    wait_for(3, 3000);
    chk_bit("light off", 1'b0, backlight_on);
    wait_for(2, 100);
  endtask

  // proximity wake: inactive back to deep, active stays and goes fast
  task automatic t_prox();
    prox_mode = 1'b1;
    wait_for(0, 1000);
    chk_bit("prox only", 1'b1, prox_only);
    wait_for(2, 100);
    chk_bit("light idle", 1'b0, backlight_on);
    touch_in = 1'b1;
    wait_for(0, 1000);
    wait_for(1, 40);
    wait_for(0, 10);
    chk_bit("prox fast", 1'b1, fast_rate);
    chk_bit("prox released", 1'b0, prox_only);
    chk_bit("prox light", 1'b1, backlight_on);
    touch_in = 1'b0;
    prox_mode = 1'b0;
    gang_mode = 1'b0;
    wait_for(3, 3000);
    wait_for(2, 100);
  endtask

  // every edge select against both pin edges
  task automatic t_gpio();
    logic woke;
    slow_period = 16'hffff;
    repeat (50) @(negedge sys_clk);
    wait_for(2, 100);
    for (int s = 0; s < 4; s++) begin
      gpio_edge_sel = s[1:0];
      for (int e = 0; e < 2; e++) begin
        gpio_pin = ~gpio_pin;
        woke = 1'b0;
        repeat (20) begin
          @(negedge sys_clk);
          if (power_mode !== seq_pkg::PM_DEEP) woke = 1'b1;
        end
        chk_bit("gpio wake", gpio_edge_sel[e], woke);
        wait_for(2, 200);
      end
    end
  endtask

  task automatic t_i2c();
    repeat (30) @(negedge sys_clk);
    chk_mode("no match", seq_pkg::PM_DEEP);
    i2c_addr_match = 1'b1;
    @(negedge sys_clk);
    i2c_addr_match = 1'b0;
    repeat (3) @(negedge sys_clk);
    chk_mode("match wake", seq_pkg::PM_ACTIVE);
    chk_bit("match cpu", 1'b1, processor_clk_en);
    repeat (10) @(negedge sys_clk);
    chk_mode("serve", seq_pkg::PM_ACTIVE);
    i2c_done = 1'b1;
    @(negedge sys_clk);
    i2c_done = 1'b0;
    wait_for(2, 3);
  endtask

  // completion right after start, before sleep has settled
  task automatic t_early();
    delay_cfg = 8'h00;
    slow_period = 16'h0004;
    wait_for(0, 1000);
    wait_for(4, 10);
    chk_mode("pending in scan", seq_pkg::PM_SLEEP);
    wait_for(1, 10);
    chk_bit("pending served", 1'b0, scan_irq_pending);
    wait_for(2, 20);
    // host request during a scan waits for the result, then is served
    wait_for(0, 1000);
    i2c_addr_match = 1'b1;
    @(negedge sys_clk);
    i2c_addr_match = 1'b0;
    wait_for(1, 20);
    repeat (3) @(negedge sys_clk);
    chk_mode("late host", seq_pkg::PM_ACTIVE);
    i2c_done = 1'b1;
    @(negedge sys_clk);
    i2c_done = 1'b0;
    wait_for(2, 3);
  endtask

  initial begin
    sys_clk = 1'b0;
    sys_rst = 1'b1;
    gpio_pin = 1'b0;
    gpio_edge_sel = 2'h1;
    i2c_addr_match = 1'b0;
    i2c_done = 1'b0;
    gang_mode = 1'b0;
    prox_mode = 1'b0;
    slow_period = 16'h0004;
    fast_period = 16'h0002;
    idle_limit = 16'h0006;
    touch_in = 1'b0;
    delay_cfg = 8'h0a;
    n_mismatch = 0;
    total_checks = 0;
    repeat (5) @(negedge sys_clk);
    sys_rst = 1'b0;
    t_reset();
    t_gang();
    t_prox();
    t_gpio();
    t_i2c();
    t_early();
    wrap_up();
  end
endmodule // tb_top
`default_nettype wire
